// ### design/adc_pacer_trigger_control.sv
// Conversion pacing, external trigger gating, channel pairing and output update control
// Function
// - Two independent 16-bit counters advance on a shared 10 MHz time base.
// - Counter 0 counts rising events seen on the event input.
// - Counter 1 is a 16-bit interval timer producing periodic pacer pulses.
// - Each rising edge of the pacer output starts one conversion and falling edges start none.
// - A rising edge on the external trigger input also starts a conversion.
// - The external trigger is ignored while the gate input is high and works again once it is low.
// - In differential mode even channel n (0 to 14) is paired with channel n+1.
// - The selector offers 16 single-ended inputs or up to 8 differential pairs.
// - Two analog outputs are each updated by a single individual write.
// - The external trigger pin starts a conversion on every rising edge held high for two or more clock cycles while enabled and while the gate input is low.
`timescale 1ns/1ps
`default_nettype none
`include "adc_pacer_params.svh"
module adc_pacer_trigger_control
    import adc_pacer_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_event_in,
    input  wire logic                 i_external_conversion_trigger,
    input  wire logic                 i_gate,
    input  wire logic                 i_pacer_enable,
    input  wire logic                 i_external_enable,
    input  wire logic [`CNT_W-1:0]    i_pacer_divisor,
    input  wire logic                 i_event_clear,
    input  wire logic                 i_differential,
    input  wire logic [`CHAN_W-1:0]   i_channel,
    input  wire logic                 i_ao_first_write,
    input  wire logic                 i_ao_second_write,
    input  wire logic [`AO_W-1:0]     i_ao_data,
    output logic [`CNT_W-1:0]         o_event_count,
    output logic                      o_pacer_out,
    output logic                      o_conversion_start,
    output logic                      o_start_from_external,
    output logic [`CHAN_W-1:0]        o_mux_positive,
    output logic [`CHAN_W-1:0]        o_mux_negative,
    output logic                      o_mux_differential,
    output logic [`AO_W-1:0]          o_analog_output_first,
    output logic [`AO_W-1:0]          o_analog_output_second
);
    logic [`TB_DIV_W-1:0] tb_count;
    logic                 tb_tick;
    logic                 event_level;
    logic                 event_rise;
    logic                 event_pending;
    logic                 trig_level;
    logic                 trig_rise;
    logic                 gate_level;
    logic                 gate_rise;
    logic [`CNT_W-1:0]    pacer_count;
    logic [`CNT_W-1:0]    pacer_half;
    logic                 pacer_prev;
    logic                 next_pacer_rise;
    logic                 next_ext_start;
    start_src_t           next_src;

    edge_sync u_event_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async (i_event_in),
        .o_level (event_level),
        .o_rise  (event_rise)
    );

    edge_sync u_trig_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async (i_external_conversion_trigger),
        .o_level (trig_level),
        .o_rise  (trig_rise)
    );

    edge_sync u_gate_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async (i_gate),
        .o_level (gate_level),
        .o_rise  (gate_rise)
    );

    // Shared 10 MHz time base for both counters
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tb_count <= '0;
            tb_tick  <= 1'b0;
        end else if (tb_count == `TB_DIV_W'(`TB_DIV - 1)) begin
            tb_count <= '0;
            tb_tick  <= 1'b1;
        end else begin
            tb_count <= tb_count + `TB_DIV_W'(1);
            tb_tick  <= 1'b0;
        end
    end

    // Events are held until the next time-base tick; only one pending event is kept between ticks
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            event_pending <= 1'b0;
            o_event_count <= `CNT_RESET;
        end else begin
            if (i_event_clear) begin
                o_event_count <= `CNT_RESET;
                event_pending <= event_rise;
            end else if (tb_tick) begin
                if (event_pending || event_rise) begin
                    o_event_count <= o_event_count + `CNT_W'(1);
                end
                event_pending <= 1'b0;
            end else if (event_rise) begin
                event_pending <= 1'b1;
            end
        end
    end

    // Pacer timer: square wave, high for the first half of each period
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pacer_count <= `CNT_RESET;
            pacer_half  <= `CNT_RESET;
            o_pacer_out <= 1'b0;
        end else if (!i_pacer_enable) begin
            pacer_count <= `CNT_RESET;
            pacer_half  <= `CNT_RESET;
            o_pacer_out <= 1'b0;
        end else if (tb_tick) begin
            if (pacer_count == `CNT_RESET) begin
                pacer_count <= (i_pacer_divisor < `CNT_W'(2)) ? `CNT_W'(1) : i_pacer_divisor - `CNT_W'(1);
                // Half period latched at reload, from the same effective divisor, so short periods still toggle
                pacer_half  <= (i_pacer_divisor < `CNT_W'(2)) ? `CNT_W'(1) : {1'b0, i_pacer_divisor[`CNT_W-1:1]};
                o_pacer_out <= 1'b1;
            end else begin
                pacer_count <= pacer_count - `CNT_W'(1);
                if (pacer_count <= pacer_half) begin
                    o_pacer_out <= 1'b0;
                end
            end
        end
    end

    // Only the low-to-high step of the pacer may start a conversion
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pacer_prev <= 1'b0;
        end else begin
            pacer_prev <= o_pacer_out;
        end
    end

    always_comb begin
        next_pacer_rise = o_pacer_out & ~pacer_prev;
        // Gate level and its rising edge both block, so a trigger that arrives with the gate cannot slip in
        next_ext_start  = i_external_enable & trig_rise & ~gate_level & ~gate_rise & trig_level;
        next_src        = next_ext_start ? SRC_EXTERNAL : SRC_PACER;
    end

    // One start per cycle; coincident sources merge into one conversion
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_conversion_start    <= 1'b0;
            o_start_from_external <= 1'b0;
        end else begin
            o_conversion_start    <= next_pacer_rise | next_ext_start;
            o_start_from_external <= (next_src == SRC_EXTERNAL);
        end
    end

    // Channel selection: odd channels are forced to their even partner in differential mode
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mux_positive     <= '0;
            o_mux_negative     <= '0;
            o_mux_differential <= 1'b0;
        end else if (i_differential) begin
            o_mux_positive     <= {i_channel[`CHAN_W-1:1], 1'b0};
            o_mux_negative     <= {i_channel[`CHAN_W-1:1], 1'b1};
            o_mux_differential <= 1'b1;
        end else begin
            o_mux_positive     <= i_channel;
            o_mux_negative     <= i_channel;
            o_mux_differential <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_analog_output_first  <= `AO_RESET;
            o_analog_output_second <= `AO_RESET;
        end else begin
            if (i_ao_first_write) begin
                o_analog_output_first <= i_ao_data;
            end
            if (i_ao_second_write) begin
                o_analog_output_second <= i_ao_data;
            end
        end
    end
endmodule : adc_pacer_trigger_control
`default_nettype wire

// ### design/edge_sync.sv
// Two-flop synchroniser with a registered rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_rise
);
    logic meta;
    logic prev;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta    <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta    <= i_async;
            o_level <= meta;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev   <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            prev   <= o_level;
            o_rise <= o_level & ~prev;
        end
    end
endmodule : edge_sync
`default_nettype wire

// ### include/adc_pacer_params.svh
// Constants for the conversion pacing and trigger control block
`ifndef ADC_PACER_PARAMS_SVH
`define ADC_PACER_PARAMS_SVH
`define CNT_W              16
`define CLK_FREQ_MHZ       100
`define TB_FREQ_MHZ        10
`define TB_DIV             (`CLK_FREQ_MHZ / `TB_FREQ_MHZ)
`define TB_DIV_W           4
`define DIV_RESET          16'h0064
`define CNT_RESET          16'h0000
`define CHAN_W             4
`define AO_W               12
`define AO_RESET           12'h000
`endif

// ### include/adc_pacer_pkg.sv
// Types for the conversion pacing and trigger control block
package adc_pacer_pkg;
    typedef enum logic {
        SRC_PACER,
        SRC_EXTERNAL
    } start_src_t;
endpackage : adc_pacer_pkg

// ### tb/adc_pacer_properties.sv
// Checker for conversion pacing, channel pairing and output update
`timescale 1ns/1ps
`default_nettype none
`include "adc_pacer_params.svh"
module adc_pacer_properties (
    input wire logic              i_mclk,
    input wire logic              i_nrst,
    input wire logic              i_pacer_enable,
    input wire logic              i_differential,
    input wire logic [`CHAN_W-1:0] i_channel,
    input wire logic              i_ao_first_write,
    input wire logic [`AO_W-1:0]  i_ao_data,
    input wire logic [`CNT_W-1:0] o_event_count,
    input wire logic              o_pacer_out,
    input wire logic              o_conversion_start,
    input wire logic              o_start_from_external,
    input wire logic [`CHAN_W-1:0] o_mux_positive,
    input wire logic [`CHAN_W-1:0] o_mux_negative,
    input wire logic              o_mux_differential,
    input wire logic [`AO_W-1:0]  o_analog_output_first
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    pacer_start_a: assert property ($rose(o_pacer_out) |-> ##1 o_conversion_start)
        else $error("pacer rise gave no start");
    start_single_a: assert property (o_conversion_start |=> !o_conversion_start)
        else $error("start pulse too long");
    pacer_off_a: assert property (!i_pacer_enable |=> !o_pacer_out)
        else $error("pacer high while disabled");
    diff_pair_a: assert property (o_mux_differential |-> !o_mux_positive[0] && o_mux_negative == (o_mux_positive | 4'h1))
        else $error("bad differential pair");
    single_mux_a: assert property (!o_mux_differential |-> o_mux_negative == o_mux_positive)
        else $error("single-ended sides differ");
    mode_follow_a: assert property (1'b1 |=> o_mux_differential == $past(i_differential)
        && o_mux_positive[3:1] == $past(i_channel[3:1]))
        else $error("selector did not follow");
    ao_write_a: assert property (i_ao_first_write |=> o_analog_output_first == $past(i_ao_data))
        else $error("first output not written");
    ao_hold_a: assert property (!i_ao_first_write |=> $stable(o_analog_output_first))
        else $error("first output moved without write");
    event_step_a: assert property ($changed(o_event_count) |->
        o_event_count == $past(o_event_count) + 16'h0001 || o_event_count == 16'h0000)
        else $error("event count jumped");
    cover property (o_conversion_start && o_start_from_external);
    cover property ($rose(o_pacer_out));
    cover property (o_mux_differential);
endmodule : adc_pacer_properties
bind adc_pacer_trigger_control adc_pacer_properties i_adc_pacer_properties (.*);
`default_nettype wire

// ### tb/signal_sources.sv
// Model of the event source, trigger wiring and gate
`timescale 1ns/1ps
`default_nettype none
module signal_sources (
    input  wire logic i_mclk,
    output logic      o_event,
    output logic      o_trigger,
    output logic      o_gate
);
    initial begin
        o_event = 1'b0;
        o_trigger = 1'b0;
        o_gate = 1'b0;
    end
    // Long levels so the synchroniser sees both; event rate stays under one per tick
    task automatic pulse(input bit trig);
        @(posedge i_mclk);
        if (trig) o_trigger <= 1'b1;
        else o_event <= 1'b1;
        repeat (4) @(posedge i_mclk);
        o_trigger <= 1'b0;
        o_event <= 1'b0;
        repeat (12) @(posedge i_mclk);
    endtask : pulse
    task automatic gate(input bit v);
        @(posedge i_mclk);
        o_gate <= v;
    endtask : gate
endmodule : signal_sources
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the conversion pacing block
`timescale 1ns/1ps
`default_nettype none
`include "adc_pacer_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module testbench;
    logic i_mclk = 1'b0, i_nrst = 1'b0, i_pacer_enable = 1'b0, i_external_enable = 1'b0;
    logic i_event_clear = 1'b0, i_differential = 1'b0, i_ao_first_write = 1'b0, i_ao_second_write = 1'b0;
    logic [15:0] i_pacer_divisor = 16'h0005;
    logic [3:0]  i_channel = 4'h0;
    logic [11:0] i_ao_data = 12'h000, e1 = 12'h000, e2 = 12'h000;
    wire logic i_event_in, i_external_conversion_trigger, i_gate, o_pacer_out, o_conversion_start;
    wire logic o_start_from_external, o_mux_differential;
    wire logic [15:0] o_event_count;
    wire logic [3:0]  o_mux_positive, o_mux_negative;
    wire logic [11:0] o_analog_output_first, o_analog_output_second;
    int miscompares = 0, n_checks = 0;
    always #5 i_mclk = ~i_mclk;
    adc_pacer_trigger_control i_adc_pacer_trigger_control (.*);
    signal_sources i_signal_sources (.i_mclk(i_mclk), .o_event(i_event_in),
        .o_trigger(i_external_conversion_trigger), .o_gate(i_gate));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic count(input int n, input logic ext, output int c);
        c = 0;
        repeat (n) begin
            @(posedge i_mclk);
            if (o_conversion_start === 1'b1) begin
                c++;
                `CHK(o_start_from_external, ext)
            end
        end
    endtask : count
    task automatic gap(output int k);
        @(posedge i_mclk);
        k = 1;
        while (o_conversion_start !== 1'b1 && k < 3000) begin
            @(posedge i_mclk);
            k++;
        end
    endtask : gap
    task automatic t_pacer(input logic [15:0] d);
        int k;
        i_pacer_divisor <= d;
        i_pacer_enable <= 1'b1;
        repeat (3) gap(k);
        `CHK(k, (d < 2) ? 20 : d * 10)
        i_pacer_enable <= 1'b0;
        repeat (2) @(posedge i_mclk);
        `CHK(o_pacer_out, 1'b0)
    endtask : t_pacer
    task automatic t_ext(input logic en, input bit g, input int exp);
        int c;
        i_external_enable <= en;
        i_signal_sources.gate(g);
        repeat (4) @(posedge i_mclk);
        fork
            i_signal_sources.pulse(1'b1);
            count(20, 1'b1, c);
        join
        `CHK(c, exp)
    endtask : t_ext
    task automatic ao(input logic w1, input logic w2, input logic [11:0] v);
        i_ao_data <= v;
        i_ao_first_write <= w1;
        i_ao_second_write <= w2;
        @(posedge i_mclk);
        i_ao_first_write <= 1'b0;
        i_ao_second_write <= 1'b0;
        @(posedge i_mclk);
        if (w1) e1 = v;
        if (w2) e2 = v;
        `CHK(o_analog_output_first, e1)
        `CHK(o_analog_output_second, e2)
    endtask : ao
    task automatic t_mux();
        for (int ch = 0; ch < 16; ch++) begin
            for (int d = 0; d < 2; d++) begin
                i_channel <= ch[3:0];
                i_differential <= d[0];
                repeat (2) @(posedge i_mclk);
                `CHK(o_mux_positive, d ? ch[3:0] & 4'hE : ch[3:0])
                `CHK(o_mux_negative, d ? ch[3:0] | 4'h1 : ch[3:0])
                `CHK(o_mux_differential, d[0])
            end
        end
    endtask : t_mux
    task automatic t_events();
        repeat (3) i_signal_sources.pulse(1'b0);
        repeat (12) @(posedge i_mclk);
        `CHK(o_event_count, 16'h0003)
        i_event_clear <= 1'b1;
        @(posedge i_mclk);
        i_event_clear <= 1'b0;
        repeat (2) @(posedge i_mclk);
        `CHK(o_event_count, 16'h0000)
    endtask : t_events
    initial begin
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        t_mux();
        ao(1'b1, 1'b0, 12'hA5C);
        ao(1'b0, 1'b1, 12'h3F1);
        ao(1'b1, 1'b1, 12'hFFF);
        t_events();
        t_ext(1'b1, 1'b0, 1);
        t_ext(1'b1, 1'b1, 0);
        t_ext(1'b1, 1'b0, 1);
        t_ext(1'b0, 1'b0, 0);
        t_pacer(16'h0005);
        t_pacer(16'h0001);
        finish_test();
    end
    // Slack of over fifty times the expected run of under 500 cycles so slow pacer settings still fit
    initial begin
        repeat (30000) @(posedge i_mclk);
        miscompares++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
